/* hw/sar_converter.sv */
// sar_converter digital control: scan sequencer, averaging, result packing and dma
// assumes wishbone classic slave and master, analog core answering conv_done
`timescale 1ns/100ps
`include "sar_converter_cfg.svh"
module sar_converter (
  input wire logic clk, // 50 MHz clock
  input wire logic reset, // async, active high
  input wire logic wb_cyc, // bus cycle
  input wire logic wb_stb, // strobe
  input wire logic wb_we, // write
  input wire logic [31:0] wb_adr, // byte address
  input wire logic [3:0] wb_sel, // byte enables
  input wire logic [31:0] wb_dat_w, // write data
  output logic [31:0] wb_dat_r, // read data
  output logic wb_ack, // acknowledge
  input wire logic sample_trig, // sample trigger pulse from routing fabric
  output sar_converter_pkg::afe_ctrl_s afe, // analog core control
  input wire logic afe_conv_done, // conversion finished pulse
  input wire logic [15:0] afe_code, // signed code, 2^14 = full scale
  output sar_converter_pkg::event_s events, // one-cycle event pulses
  output sar_converter_pkg::dma_req_s dma, // dma master request
  input wire logic dma_ack // dma acknowledge
);
  logic wb_ack_q, wb_ack_d;
  logic [31:0] wb_dat_q, wb_dat_d;
  logic [31:0] ptr_q, ptr_d;
  logic [14:0] max_q, max_d, max_act_q, max_act_d;
  logic [14:0] amount_q, amount_d, taken_q, taken_d;
  logic [1:0] res_q, res_d;
  logic [3:0] ovs_q, ovs_d;
  logic [12:0] srate_q, srate_d;
  logic [4:0] evst_q, evst_d;
  sar_converter_pkg::channel_setup_s ch_cfg_q [8];
  sar_converter_pkg::channel_setup_s ch_cfg_d [8];
  sar_converter_pkg::seq_state_e state_q, state_d;
  logic [2:0] cur_q, cur_d;
  logic [11:0] acq_q, acq_d;
  logic [23:0] acc_q, acc_d;
  logic [8:0] avg_q, avg_d;
  logic half_q, half_d;
  logic [15:0] lo_q, lo_d;
  logic [31:0] waddr_q, waddr_d;
  logic [1:0] wnum_q, wnum_d;
  logic started_q, started_d, stop_pend_q, stop_pend_d;
  logic [10:0] tmr_q, tmr_d;
  sar_converter_pkg::afe_ctrl_s afe_q, afe_d;
  sar_converter_pkg::event_s ev_q, ev_d;
  sar_converter_pkg::dma_req_s dma_q, dma_d;
  logic [7:0] ch_en;
  logic wb_hit, wr, t_start, t_sample, t_stop, timer_fire, trig;
  logic first_found, next_found, launch, advance;
  logic [2:0] first_ch, next_ch, launch_ch;
  logic [3:0] sh;
  logic [15:0] scaled, avg_val;
  logic [23:0] acc_new;
  logic [8:0] avg_goal;
  logic [4:0] ev_bits;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_en
      assign ch_en[gi] = ch_cfg_q[gi].positive_pin_select != 4'h0;
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [11:0] acq_cycles(input logic [2:0] code);
    logic [11:0] c;
    case (code)
      3'h0: c = 12'(`ACQUISITION_TIME_CYC(`TACQ0_US));
      3'h1: c = 12'(`ACQUISITION_TIME_CYC(`TACQ1_US));
      3'h2: c = 12'(`ACQUISITION_TIME_CYC(`TACQ2_US));
      3'h3: c = 12'(`ACQUISITION_TIME_CYC(`TACQ3_US));
      3'h4: c = 12'(`ACQUISITION_TIME_CYC(`TACQ4_US));
      default: c = 12'(`ACQUISITION_TIME_CYC(`TACQ5_US));
    endcase
    return c;
  endfunction

  always_comb begin
    first_found = 1'b0;
    first_ch = 3'h0;
    next_found = 1'b0;
    next_ch = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (ch_en[i]) begin
        first_found = 1'b1;
        first_ch = 3'(i);
        if (3'(i) > cur_q) begin
          next_found = 1'b1;
          next_ch = 3'(i);
        end
      end
    end
  end

  always_comb begin
    wb_hit = wb_cyc & wb_stb & ~wb_ack_q;
    wr = wb_hit & wb_we;
    t_start = wr & (wb_adr[11:0] == `OFF_TASK_START) & wb_dat_w[0];
    t_sample = wr & (wb_adr[11:0] == `OFF_TASK_SAMPLE) & wb_dat_w[0];
    t_stop = wr & (wb_adr[11:0] == `OFF_TASK_STOP) & wb_dat_w[0];
    timer_fire = started_q & srate_q[`SRATE_MODE] & (tmr_q == 11'h001);
    trig = (t_sample | sample_trig | timer_fire) & started_q;
    // shift from 14-bit raw scale down to resolution, one more when differential
    case (res_q)
      2'h0: sh = 4'h6;
      2'h1: sh = 4'h4;
      2'h2: sh = 4'h2;
      default: sh = (ovs_q == 4'h0) ? 4'h2 : 4'h0;
    endcase
    sh = sh + {3'h0, afe_q.diff};
    scaled = $signed(afe_code) >>> sh;
    acc_new = acc_q + {{8{scaled[15]}}, scaled};
    avg_val = 16'($signed(acc_new) >>> ovs_q);
    avg_goal = 9'h001 << ovs_q;
  end

  always_comb begin
    wb_ack_d = wb_hit;
    wb_dat_d = 32'h0000_0000;
    ptr_d = ptr_q;
    max_d = max_q;
    max_act_d = max_act_q;
    amount_d = amount_q;
    taken_d = taken_q;
    res_d = res_q;
    ovs_d = ovs_q;
    srate_d = srate_q;
    ch_cfg_d = ch_cfg_q;
    state_d = state_q;
    cur_d = cur_q;
    acq_d = acq_q;
    acc_d = acc_q;
    avg_d = avg_q;
    half_d = half_q;
    lo_d = lo_q;
    waddr_d = waddr_q;
    wnum_d = wnum_q;
    started_d = started_q;
    stop_pend_d = stop_pend_q;
    tmr_d = tmr_q;
    afe_d = afe_q;
    afe_d.conv_start = 1'b0;
    ev_d = '0;
    dma_d = dma_q;
    launch = 1'b0;
    launch_ch = first_ch;
    advance = 1'b0;
    ev_bits = 5'h00;
    if (wb_hit & ~wb_we) begin
      if (wb_adr[11:5] == `OFF_CH_HI) begin
        wb_dat_d = {16'h0000, ch_cfg_q[wb_adr[4:2]]};
      end else begin
        case (wb_adr[11:0])
          `OFF_PTR: wb_dat_d = ptr_q;
          `OFF_MAXCNT: wb_dat_d = {17'h0, max_q};
          `OFF_AMOUNT: wb_dat_d = {17'h0, amount_q};
          `OFF_RES: wb_dat_d = {30'h0, res_q};
          `OFF_OVS: wb_dat_d = {28'h0, ovs_q};
          `OFF_SRATE: wb_dat_d = {19'h0, srate_q};
          `OFF_EVENTS: wb_dat_d = {27'h0, evst_q};
          `OFF_STATUS: wb_dat_d = {28'h0, started_q, state_q};
          default: wb_dat_d = 32'h0000_0000;
        endcase
      end
    end
    if (wr) begin
      if (wb_adr[11:5] == `OFF_CH_HI) begin
        ch_cfg_d[wb_adr[4:2]] = 16'(merge({16'h0000, ch_cfg_q[wb_adr[4:2]]}, wb_dat_w,
                                          wb_sel));
      end else begin
        case (wb_adr[11:0])
          `OFF_PTR: ptr_d = merge(ptr_q, wb_dat_w, wb_sel);
          `OFF_MAXCNT: max_d = 15'(merge({17'h0, max_q}, wb_dat_w, wb_sel));
          `OFF_RES: res_d = 2'(merge({30'h0, res_q}, wb_dat_w, wb_sel));
          `OFF_OVS: ovs_d = 4'(merge({28'h0, ovs_q}, wb_dat_w, wb_sel));
          `OFF_SRATE: srate_d = 13'(merge({19'h0, srate_q}, wb_dat_w, wb_sel));
          default: ;
        endcase
      end
    end
    if (started_q & srate_q[`SRATE_MODE]) begin
      tmr_d = (tmr_q <= 11'h001) ? srate_q[10:0] : tmr_q - 11'h001;
    end
    case (state_q)
      sar_converter_pkg::ST_IDLE: begin
        if (t_start) begin
          waddr_d = ptr_q;
          max_act_d = max_q;
          amount_d = 15'h0000;
          taken_d = 15'h0000;
          half_d = 1'b0;
          acc_d = 24'h00_0000;
          avg_d = 9'h000;
          started_d = 1'b1;
          stop_pend_d = 1'b0;
          tmr_d = srate_q[10:0];
          ev_d.started = 1'b1;
        end else if (t_stop) begin
          started_d = 1'b0;
          ev_d.stopped = 1'b1;
        end else if (trig & first_found) begin
          launch = 1'b1;
        end
      end
      sar_converter_pkg::ST_ACQ: begin
        if (t_stop) begin
          state_d = sar_converter_pkg::ST_IDLE;
          afe_d.sample = 1'b0;
          started_d = 1'b0;
          ev_d.stopped = 1'b1;
        end else if (acq_q <= 12'h001) begin
          afe_d.sample = 1'b0;
          afe_d.conv_start = 1'b1;
          state_d = sar_converter_pkg::ST_CONV;
        end else begin
          acq_d = acq_q - 12'h001;
        end
      end
      sar_converter_pkg::ST_CONV: begin
        if (t_stop) begin
          state_d = sar_converter_pkg::ST_IDLE;
          started_d = 1'b0;
          ev_d.stopped = 1'b1;
        end else if (afe_conv_done) begin
          ev_d.done = 1'b1;
          if (avg_q + 9'h001 == avg_goal) begin
            ev_d.result_ready = 1'b1;
            acc_d = 24'h00_0000;
            avg_d = 9'h000;
            taken_d = taken_q + 15'h0001;
            if (half_q) begin
              dma_d = '{1'b1, 1'b1, 1'b1, 4'hF, waddr_q, {avg_val, lo_q}};
              wnum_d = 2'h2;
              state_d = sar_converter_pkg::ST_DMA;
            end else if (taken_q + 15'h0001 == max_act_q) begin
              dma_d = '{1'b1, 1'b1, 1'b1, 4'h3, waddr_q, {16'h0000, avg_val}};
              wnum_d = 2'h1;
              state_d = sar_converter_pkg::ST_DMA;
            end else begin
              lo_d = avg_val;
              half_d = 1'b1;
              advance = 1'b1;
            end
          end else begin
            acc_d = acc_new;
            avg_d = avg_q + 9'h001;
            advance = 1'b1;
          end
        end
      end
      sar_converter_pkg::ST_DMA: begin
        if (t_stop) begin
          stop_pend_d = 1'b1;
        end
        if (dma_ack) begin
          dma_d = '0;
          half_d = 1'b0;
          waddr_d = waddr_q + 32'h0000_0004;
          amount_d = amount_q + {13'h0, wnum_q};
          if (amount_q + {13'h0, wnum_q} == max_act_q) begin
            ev_d.buf_end = 1'b1;
            started_d = 1'b0;
            state_d = sar_converter_pkg::ST_IDLE;
          end else if (stop_pend_q | t_stop) begin
            ev_d.stopped = 1'b1;
            started_d = 1'b0;
            stop_pend_d = 1'b0;
            state_d = sar_converter_pkg::ST_IDLE;
          end else begin
            advance = 1'b1;
          end
        end
      end
      default: state_d = sar_converter_pkg::ST_IDLE;
    endcase
    if (advance) begin
      if (next_found) begin
        launch = 1'b1;
        launch_ch = next_ch;
      end else begin
        state_d = sar_converter_pkg::ST_IDLE;
      end
    end
    if (launch) begin
      cur_d = launch_ch;
      acq_d = acq_cycles(ch_cfg_q[launch_ch].acquisition_time);
      afe_d.sample = 1'b1;
      afe_d.ch = launch_ch;
      afe_d.pos_sel = ch_cfg_q[launch_ch].positive_pin_select;
      afe_d.diff = ch_cfg_q[launch_ch].diff;
      afe_d.neg_sel = ch_cfg_q[launch_ch].diff ?
                      ch_cfg_q[launch_ch].negative_pin_select : 4'h0;
      afe_d.gain = ch_cfg_q[launch_ch].gain;
      afe_d.ref_int = ch_cfg_q[launch_ch].ref_int;
      state_d = sar_converter_pkg::ST_ACQ;
    end
    ev_bits[`EV_STARTED] = ev_d.started;
    ev_bits[`EV_END] = ev_d.buf_end;
    ev_bits[`EV_DONE] = ev_d.done;
    ev_bits[`EV_RESDONE] = ev_d.result_ready;
    ev_bits[`EV_STOPPED] = ev_d.stopped;
    evst_d = evst_q;
    if (wr & (wb_adr[11:0] == `OFF_EVENTS) & wb_sel[0]) begin
      evst_d = evst_q & ~wb_dat_w[4:0];
    end
    evst_d = evst_d | ev_bits;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
      ptr_q <= 32'h0000_0000;
      max_q <= 15'h0000;
      max_act_q <= 15'h0000;
      amount_q <= 15'h0000;
      taken_q <= 15'h0000;
      res_q <= 2'h0;
      ovs_q <= 4'h0;
      srate_q <= 13'h0000;
      evst_q <= 5'h00;
      for (int i = 0; i < 8; i++) begin
        ch_cfg_q[i] <= '0;
      end
      state_q <= sar_converter_pkg::ST_IDLE;
      cur_q <= 3'h0;
      acq_q <= 12'h000;
      acc_q <= 24'h00_0000;
      avg_q <= 9'h000;
      half_q <= 1'b0;
      lo_q <= 16'h0000;
      waddr_q <= 32'h0000_0000;
      wnum_q <= 2'h0;
      started_q <= 1'b0;
      stop_pend_q <= 1'b0;
      tmr_q <= 11'h000;
      afe_q <= '0;
      ev_q <= '0;
      dma_q <= '0;
    end else begin
      wb_ack_q <= wb_ack_d;
      wb_dat_q <= wb_dat_d;
      ptr_q <= ptr_d;
      max_q <= max_d;
      max_act_q <= max_act_d;
      amount_q <= amount_d;
      taken_q <= taken_d;
      res_q <= res_d;
      ovs_q <= ovs_d;
      srate_q <= srate_d;
      evst_q <= evst_d;
      ch_cfg_q <= ch_cfg_d;
      state_q <= state_d;
      cur_q <= cur_d;
      acq_q <= acq_d;
      acc_q <= acc_d;
      avg_q <= avg_d;
      half_q <= half_d;
      lo_q <= lo_d;
      waddr_q <= waddr_d;
      wnum_q <= wnum_d;
      started_q <= started_d;
      stop_pend_q <= stop_pend_d;
      tmr_q <= tmr_d;
      afe_q <= afe_d;
      ev_q <= ev_d;
      dma_q <= dma_d;
    end
  end

  assign wb_ack = wb_ack_q;
  assign wb_dat_r = wb_dat_q;
  assign afe = afe_q;
  assign events = ev_q;
  assign dma = dma_q;

  sequence s_halted;
    (state_q == sar_converter_pkg::ST_IDLE) && !afe_q.sample && ev_q.stopped;
  endsequence
  sequence s_busy;
    (state_q == sar_converter_pkg::ST_ACQ) || (state_q == sar_converter_pkg::ST_CONV);
  endsequence

  AST_PTR_LATCH: assert property (@(posedge clk) disable iff (reset)
    t_start && state_q == sar_converter_pkg::ST_IDLE |=> waddr_q == $past(ptr_q) && ev_q.started)
    else $error("pointer not latched at start");
  AST_PIN_ROUTE: assert property (@(posedge clk) disable iff (reset)
    $rose(afe_q.sample) |-> afe_q.pos_sel == ch_cfg_q[afe_q.ch].positive_pin_select
      && afe_q.pos_sel != 4'h0)
    else $error("sampled channel not routed by its pin select");
  AST_SE_GROUND: assert property (@(posedge clk) disable iff (reset)
    afe_q.sample && !afe_q.diff |-> afe_q.neg_sel == 4'h0)
    else $error("single-ended negative input not grounded");
  AST_DONE_EVT: assert property (@(posedge clk) disable iff (reset)
    state_q == sar_converter_pkg::ST_CONV && afe_conv_done && !t_stop |=> ev_q.done)
    else $error("no done event after conversion");
  AST_RES_EVERY: assert property (@(posedge clk) disable iff (reset)
    ev_q.done && $past(ovs_q) == 4'h0 |-> ev_q.result_ready)
    else $error("result ready missing without averaging");
  AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (reset)
    trig && state_q == sar_converter_pkg::ST_ACQ && !t_stop |=> $stable(cur_q))
    else $error("sample trigger disturbed a running scan");
  AST_STOP_ABORT: assert property (@(posedge clk) disable iff (reset)
    t_stop ##0 s_busy |=> s_halted)
    else $error("stop did not abort the conversion");
  AST_DMA_HOLD: assert property (@(posedge clk) disable iff (reset)
    dma_q.cyc && !dma_ack |=> $stable(dma_q))
    else $error("dma request changed before ack");
  AST_END_COUNT: assert property (@(posedge clk) disable iff (reset)
    ev_q.buf_end |-> amount_q == max_act_q && !dma_q.cyc && !started_q)
    else $error("end event with wrong count or busy dma");
  AST_DMA_IDLE: assert property (@(posedge clk) disable iff (reset)
    ev_q.stopped |-> !dma_q.cyc && state_q == sar_converter_pkg::ST_IDLE)
    else $error("stopped event while dma busy");
endmodule

/* shared/sar_converter_cfg.svh */
// constants for the sar_converter sequencer and result dma
// assumes a 50 MHz clock and a 32-bit classic wishbone register bus
`ifndef SAR_CONVERTER_CFG_SVH
`define SAR_CONVERTER_CFG_SVH
`define OFF_TASK_START 12'h000
`define OFF_TASK_SAMPLE 12'h004
`define OFF_TASK_STOP 12'h008
`define OFF_PTR 12'h500
`define OFF_MAXCNT 12'h504
`define OFF_AMOUNT 12'h508
`define OFF_RES 12'h50C
`define OFF_OVS 12'h510
`define OFF_SRATE 12'h514
`define OFF_EVENTS 12'h518
`define OFF_STATUS 12'h51C
`define OFF_CH_HI 7'h30
`define EV_STARTED 0
`define EV_END 1
`define EV_DONE 2
`define EV_RESDONE 3
`define EV_STOPPED 4
`define SRATE_MODE 12
`define CLK_MHZ 50
`define ACQUISITION_TIME_CYC(us) ((us) * `CLK_MHZ)
`define TACQ0_US 3
`define TACQ1_US 5
`define TACQ2_US 10
`define TACQ3_US 15
`define TACQ4_US 20
`define TACQ5_US 40
`define RAW_BITS 14
`endif

/* shared/sar_converter_pkg.sv */
// types shared by the sar_converter sequencer
// assumes the constants header is included by users
package sar_converter_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACQ = 3'b001,
    ST_CONV = 3'b010,
    ST_DMA = 3'b011
  } seq_state_e;
  typedef struct packed {
    logic [3:0] positive_pin_select;
    logic [3:0] negative_pin_select;
    logic diff;
    logic [2:0] gain;
    logic ref_int;
    logic [2:0] acquisition_time;
  } channel_setup_s;
  typedef struct packed {
    logic sample;
    logic conv_start;
    logic [2:0] ch;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic diff;
    logic [2:0] gain;
    logic ref_int;
  } afe_ctrl_s;
  typedef struct packed {
    logic stopped;
    logic result_ready;
    logic done;
    logic buf_end;
    logic started;
  } event_s;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } dma_req_s;
endpackage

/* verif/ram_model.sv */
// system ram model answering the converter's result dma master
// assumes classic single cycles; lag sets the wait before each ack
`timescale 1ns/100ps
module ram_model (
  input wire logic clk, // clock
  input wire sar_converter_pkg::dma_req_s dma, // dma request
  input wire logic [3:0] lag, // wait cycles before ack
  output logic ack // acknowledge pulse
);
  logic [31:0] mem [0:1023];
  int n_wr = 0;
  int wt = 0;
  initial begin
    ack = 1'b0;
    foreach (mem[i]) mem[i] = 32'hDEADBEEF;
  end
  always @(posedge clk) begin
    ack <= 1'b0;
    wt <= 0;
    if (dma.cyc && dma.stb && !ack) begin
      wt <= wt + 1;
      if (wt >= int'(lag)) begin
        ack <= 1'b1;
        wt <= 0;
        n_wr <= n_wr + 1;
        for (int b = 0; b < 4; b++) begin
          if (dma.sel[b])
            mem[dma.adr[11:2]][8*b +: 8] <= dma.dat[8*b +: 8];
        end
      end
    end
  end
endmodule

/* verif/tb_sar_converter.sv */
// self-checking bench for the converter sequencer and result dma
// assumes ram_model on the dma side; a prompt analog core stand-in lives here
`timescale 1ns/100ps
`include "sar_converter_cfg.svh"
module tb_sar_converter;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [31:0] wb_adr = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic sample_trig = 1'b0;
  sar_converter_pkg::afe_ctrl_s afe;
  logic afe_conv_done = 1'b0;
  logic [15:0] afe_code = 16'h0;
  sar_converter_pkg::event_s events;
  sar_converter_pkg::dma_req_s dma;
  logic dma_ack;
  logic [3:0] lag = 4'h0;
  logic [31:0] rd;
  logic [2:0] chq [$];
  logic [15:0] exp_r [16];
  int n_fail = 0;
  int compares = 0;
  int n_done = 0;
  int n_rr = 0;
  int n_end = 0;
  int n_stop = 0;
  int slen = 0;
  int last_len = 0;
  int add = 0;
  int bump = 0;
  int d0, e0, s0, w0, k, i;
  int us [6] = '{3, 5, 10, 15, 20, 40};
  typedef struct {logic [7:0] en; logic [7:0] df; int rs; int mx; int nscan;} row_s;
  row_s rows [4] = '{'{8'h26, 8'h00, 2, 6, 2}, '{8'h26, 8'h04, 1, 3, 1},
                     '{8'h81, 8'h80, 0, 4, 2}, '{8'h01, 8'h00, 2, 1, 1}};

  always #10 clk = ~clk;

  sar_converter i_dut (.clk(clk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .sample_trig(sample_trig), .afe(afe),
    .afe_conv_done(afe_conv_done), .afe_code(afe_code), .events(events), .dma(dma),
    .dma_ack(dma_ack));
  ram_model i_ram (.clk(clk), .dma(dma), .lag(lag), .ack(dma_ack));

  function automatic logic [15:0] raw(input int ch);
    raw = 16'(16'h0400 * (ch + 1));
    if (ch % 2 == 1)
      raw = -raw;
  endfunction

  function automatic logic [15:0] res_of(input int ch, input int rs, input int df);
    res_of = $signed(raw(ch)) >>> (6 - 2 * rs + df);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string m);
    compares++;
    if (got != exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {20'h0, a};
    wb_sel <= 4'hF;
    wb_dat_w <= d;
    @(posedge clk);
    for (int j = 0; j < 50 && wb_ack !== 1'b1; j++) @(posedge clk);
    if (wb_ack !== 1'b1) begin
      n_fail++;
      $display("MISMATCH t=%0t register bus ack timeout", $time);
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic trig();
    @(posedge clk);
    sample_trig <= 1'b1;
    @(posedge clk);
    sample_trig <= 1'b0;
  endtask

  // wait for a done count, then for the sequencer to go idle
  task automatic idle(input int tgt);
    for (int j = 0; j < 3000 && n_done < tgt; j++) @(posedge clk);
    for (int j = 0; j < 100; j++) begin
      wb(1'b0, `OFF_STATUS, 32'h0);
      if (rd[2:0] === 3'h0)
        break;
    end
  endtask

  task automatic cfg(input int c, input logic en, input logic df, input logic [2:0] tq);
    wb(1'b1, 12'(12'h600 + 4 * c), {16'h0, en ? 4'(c + 1) : 4'h0, 4'h9, df, 3'(c), 1'(c), tq});
  endtask

  task automatic go(input logic [31:0] ptr, input int mx);
    wb(1'b1, `OFF_PTR, ptr);
    wb(1'b1, `OFF_MAXCNT, 32'(mx));
    wb(1'b1, `OFF_TASK_START, 32'h1);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // counts events, times acquisition, answers each conversion on the next cycle
  always @(posedge clk) begin
    n_done <= n_done + int'(events.done);
    n_rr <= n_rr + int'(events.result_ready);
    n_end <= n_end + int'(events.buf_end);
    n_stop <= n_stop + int'(events.stopped);
    slen <= afe.sample ? slen + 1 : 0;
    afe_conv_done <= 1'b0;
    afe_code <= ~afe_code;
    if (afe.conv_start) begin
      last_len <= slen;
      chq.push_back(afe.ch);
      afe_conv_done <= 1'b1;
      afe_code <= raw(afe.ch) + 16'(bump);
      bump <= add != 0 ? bump + add : 0;
      if (!afe.diff)
        chk({28'h0, afe.neg_sel}, 32'h0, "negative input");
    end
  end

  initial begin
    #1200000;
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({wb_ack, 26'h0, events}, 32'h0, "outputs after reset");
    cfg(0, 1'b1, 1'b0, 3'h0);
    trig();
    repeat (200) @(posedge clk);
    chk_n(n_done, 0, "sampling before start");
    for (int r = 0; r < 4; r++) begin
      chq.delete();
      e0 = n_end;
      d0 = n_done;
      lag <= 4'(3 * r);
      for (int c = 0; c < 8; c++) cfg(c, rows[r].en[c], rows[r].df[c], 3'h0);
      wb(1'b1, `OFF_RES, 32'(rows[r].rs));
      go(32'(64 * r), rows[r].mx);
      for (int s = 0; s < rows[r].nscan; s++) begin
        trig();
        idle(d0 + $countones(rows[r].en) * (s + 1));
      end
      for (i = 0; i < 100 && n_end == e0; i++) @(posedge clk);
      chk_n(n_end - e0, 1, "buffer full");
      wb(1'b0, `OFF_AMOUNT, 32'h0);
      chk(rd, 32'(rows[r].mx), "amount");
      k = 0;
      for (int s = 0; s < rows[r].nscan; s++) begin
        for (int c = 0; c < 8; c++) begin
          if (rows[r].en[c]) begin
            chk(32'(chq.pop_front()), 32'(c), "channel order");
            exp_r[k] = res_of(c, rows[r].rs, int'(rows[r].df[c]));
            k++;
          end
        end
      end
      for (int w = 0; w < (k + 1) / 2; w++)
        chk(i_ram.mem[16 * r + w], {2 * w + 1 < k ? exp_r[2 * w + 1] : 16'hDEAD, exp_r[2 * w]},
          "ram word");
    end
    lag <= 4'h0;
    d0 = n_done;
    go(32'h300, 6);
    wb(1'b1, `OFF_PTR, 32'h3F0);
    for (int t = 0; t < 6; t++) begin
      cfg(0, 1'b1, 1'b0, 3'(t));
      trig();
      if (t == 0)
        trig();
      idle(d0 + t + 1);
      chk_n(last_len, us[t] * 50, "acquisition cycles");
    end
    chk_n(n_done - d0, 6, "conversions");
    for (int w = 0; w < 3; w++) chk(i_ram.mem[192 + w], 32'h01000100, "old pointer");
    chk(i_ram.mem[252], 32'hDEADBEEF, "new pointer unused");
    s0 = n_stop;
    d0 = n_done;
    w0 = i_ram.n_wr;
    go(32'h380, 2);
    trig();
    repeat (20) @(posedge clk);
    wb(1'b1, `OFF_TASK_STOP, 32'h1);
    @(posedge clk);
    chk(32'(afe.sample), 32'h0, "sample after stop");
    repeat (200) @(posedge clk);
    chk_n(n_done - d0 + i_ram.n_wr - w0, 0, "aborted conversion");
    chk_n(n_stop - s0, 1, "stopped");
    wb(1'b1, `OFF_OVS, 32'h2);
    wb(1'b1, `OFF_RES, 32'h3);
    d0 = n_done;
    e0 = n_rr;
    add = 4;
    go(32'h3C0, 1);
    for (int t = 0; t < 4; t++) begin
      trig();
      idle(d0 + t + 1);
    end
    chk_n(n_done - d0, 4, "averaged samples");
    chk_n(n_rr - e0, 1, "averaged results");
    chk(i_ram.mem[240], 32'hDEAD0406, "average");
    add = 0;
    wb(1'b1, `OFF_OVS, 32'h0);
    // short acquisition so a 400-cycle timer period is never refused
    cfg(0, 1'b1, 1'b0, 3'h0);
    wb(1'b1, `OFF_SRATE, 32'h1190);
    d0 = n_done;
    go(32'h3E0, 100);
    for (i = 0; i < 2000 && n_done - d0 < 3; i++) @(posedge clk);
    for (i = 0; i < 1000 && n_done - d0 < 4; i++) @(posedge clk);
    chk_n(i, 400, "timer period");
    wb(1'b1, `OFF_TASK_STOP, 32'h1);
    repeat (1000) @(posedge clk);
    chk_n(n_done - d0, 4, "timer after stop");
    end_sim();
  end
endmodule
